// ===== design/off_chip_bus_defs.svh
// constants of the off-chip bus unit
`ifndef OFF_CHIP_BUS_DEFS_SVH
`define OFF_CHIP_BUS_DEFS_SVH
`define ADDR_BITS        24
`define DATA_BITS        16
`define WINDOWS          4
`define SPACE_16M        2'h0
`define SPACE_1M         2'h1
`define SPACE_256K       2'h2
`define SPACE_64K        2'h3
`define UPPER_MASK_16M   8'hff
`define UPPER_MASK_1M    8'h0f
`define UPPER_MASK_256K  8'h03
`define UPPER_MASK_64K   8'h00
`define SELECTS_IDLE     5'h1f
`define SEL_DEFAULT      3'h0
`define CNT_ZERO         4'h0
`endif

// ===== design/off_chip_bus_pkg.sv
// types of the off-chip bus unit
package off_chip_bus_pkg;
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_ALE   = 7'h02,
      ST_ALE2  = 7'h04,
      ST_DLY   = 7'h08,
      ST_STRB  = 7'h10,
      ST_RECOV = 7'h20,
      ST_HOLD  = 7'h40
   } bus_state_e;

   // one address window: base in 4 KB units, size as a power-of-two shift
   typedef struct packed {
      logic [11:0] base;
      logic [3:0]  size;
   } win_sel_s;

   typedef struct packed {
      logic       enable;
      logic       mux;
      logic       wide;
      logic       ale_long;
      logic       rw_delay;
      logic       tristate;
      logic       ready_en;
      logic       ready_polarity_bit;
      logic [3:0] waits;
   } bus_cfg_s;
endpackage : off_chip_bus_pkg

// ===== design/off_chip_bus_unit.sv
// external bus controller: windows, timing, chip selects, arbitration
`timescale 1ns/1ps
`include "off_chip_bus_defs.svh"

// Contract
// R1: single-chip mode or bus modes, 16-24 address bits, 8/16 data, muxed or not.
// R2: demuxed: address on address port, data on data port or its low byte.
// R3: muxed: one port carries address phase then data phase.
// R4: cycle length, tristate recovery, latch strobe width, strobe delay configurable.
// R5: four windows, each a select and bus configuration pair.
// R6: window four beats three, window two beats one on overlap.
// R7: addresses outside all windows use the default configuration.
// R8: five chip selects, one per window plus default.
// R9: with ready enabled, cycles extend until ready shows its active level.
// R10: per-window polarity bit picks the active level of ready.
// R11: arbitration enable bit hands request, acknowledge and hold pins to controller.
// R12: after reset the controller is master and acknowledge is an output (here acknowledge is driven only once the arbitration enable bit has been seen).
// R13: direction bit one selects slave mode; acknowledge becomes an input.
// R14: address space limited to 16M, 1M, 256K, 64K; upper lines 8, 4, 2, 0.
// R15: by default selects change half a clock after latch strobe rises.
// R16: with select timing bit set, selects change with latch strobe.
// R17: on hold, finish cycle, float, acknowledge; retake bus after release.
module off_chip_bus_unit
   import off_chip_bus_pkg::*;
#(
   parameter int ADDR_W = `ADDR_BITS,
   parameter int DATA_W = `DATA_BITS
) (
   input  wire logic                sys_clk,
   input  wire logic                reset_n,
   input  wire logic                req_valid,
   output logic                     req_ready,
   input  wire logic                req_write,
   input  wire logic [ADDR_W-1:0]   req_addr,
   input  wire logic [DATA_W-1:0]   req_wdata,
   output logic                     rsp_valid,
   output logic                     rsp_error,
   output logic [DATA_W-1:0]        rsp_rdata,
   input  wire logic                single_chip,
   input  wire logic [1:0]          addr_space_sel,
   input  wire win_sel_s [3:0]      window_select_reg,
   input  wire bus_cfg_s [3:0]      window_bus_config_reg,
   input  wire bus_cfg_s            default_bus_config_reg,
   input  wire logic                select_timing_bit,
   input  wire logic                arbitration_enable_bit,
   input  wire logic                port6_pin7_direction,
   output logic [15:0]              address_port,
   output logic [7:0]               upper_addr,
   output logic                     bus_oe,
   output logic [15:0]              data_port_out,
   output logic [15:0]              data_port_oe,
   input  wire logic [15:0]         data_port_in,
   output logic                     ale,
   output logic                     rd_n,
   output logic                     wr_n,
   output logic [4:0]               window_select_out_n,
   input  wire logic                ready_in,
   input  wire logic                hold_n,
   output logic                     bus_want_out_n,
   output logic                     bus_grant_ack_out_n,
   output logic                     bus_grant_ack_oe,
   input  wire logic                bus_grant_ack_in_n
);

   if (ADDR_W != 24 || DATA_W != 16) begin : g_check
      $error("off_chip_bus_unit supports 24 address and 16 data bits only");
   end

   function automatic logic win_hit(input logic [23:0] a, input win_sel_s w);
      win_hit = ((a[23:12] >> w.size) == (w.base >> w.size));
   endfunction : win_hit

   bus_state_e  state;
   bus_state_e  next_state;
   logic [3:0]  cnt;
   logic [3:0]  next_cnt;
   bus_cfg_s    cur_cfg;
   logic [2:0]  cur_sel;
   logic [23:0] cur_addr;
   logic [15:0] cur_wdata;
   logic        cur_write;
   logic        arb_on;
   logic [4:0]  cs_early;
   logic [4:0]  cs_half;

   // window priority: four, three, two, one, then default
   wire [3:0] hit;
   assign hit[0] = window_bus_config_reg[0].enable && win_hit(req_addr, window_select_reg[0]);
   assign hit[1] = window_bus_config_reg[1].enable && win_hit(req_addr, window_select_reg[1]);
   assign hit[2] = window_bus_config_reg[2].enable && win_hit(req_addr, window_select_reg[2]);
   assign hit[3] = window_bus_config_reg[3].enable && win_hit(req_addr, window_select_reg[3]);
   // R6 overlap priority
   wire [2:0] pick_sel = hit[3] ? 3'h4 : hit[2] ? 3'h3 :
                         hit[1] ? 3'h2 : hit[0] ? 3'h1 : `SEL_DEFAULT;
   // R5 R7 configuration choice
   wire bus_cfg_s pick_cfg = (pick_sel == `SEL_DEFAULT) ? default_bus_config_reg
                           : window_bus_config_reg[2'(pick_sel - 3'h1)];

   // R1 single chip or a disabled default refuses the access with an error
   wire no_bus = single_chip || !pick_cfg.enable;

   // R11 R12 R13 arbitration roles
   wire master  = !port6_pin7_direction;
   wire own_bus = !arb_on || master || !bus_grant_ack_in_n;
   wire hold_rq = arb_on && master && !hold_n;

   assign req_ready = (state == ST_IDLE) && !hold_rq && (own_bus || no_bus);
   wire take = req_valid && req_ready;

   // R10 ready level per window
   wire ready_ok = !cur_cfg.ready_en || (ready_in == cur_cfg.ready_polarity_bit);
   // R9 R4 cycle ends after waits and ready
   wire strb_done = (cnt == `CNT_ZERO) && ready_ok;

   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      case (state)
         ST_IDLE: begin
            if (hold_rq)
               next_state = ST_HOLD;
            else if (take && !no_bus)
               next_state = ST_ALE;
         end
         // R4 latch strobe width
         ST_ALE: begin
            next_state = cur_cfg.ale_long ? ST_ALE2 : cur_cfg.rw_delay ? ST_DLY : ST_STRB;
            next_cnt   = cur_cfg.waits;
         end
         ST_ALE2: begin
            next_state = cur_cfg.rw_delay ? ST_DLY : ST_STRB;
         end
         // R4 strobe delay
         ST_DLY: begin
            next_state = ST_STRB;
         end
         ST_STRB: begin
            if (strb_done) begin
               next_state = ST_RECOV;
               next_cnt   = {3'h0, cur_cfg.tristate};
            end else if (cnt != `CNT_ZERO) begin
               next_cnt = cnt - 4'h1;
            end
         end
         // R4 tristate recovery
         ST_RECOV: begin
            if (cnt == `CNT_ZERO)
               next_state = ST_IDLE;
            else
               next_cnt = cnt - 4'h1;
         end
         // R17 give bus back only once hold is withdrawn
         ST_HOLD: begin
            if (hold_n || !arb_on)
               next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         cnt   <= `CNT_ZERO;
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         cur_cfg   <= '0;
         cur_sel   <= `SEL_DEFAULT;
         cur_addr  <= 24'h00_0000;
         cur_wdata <= 16'h0000;
         cur_write <= 1'b0;
      end else if (take) begin
         cur_cfg   <= pick_cfg;
         cur_sel   <= pick_sel;
         cur_addr  <= req_addr;
         cur_wdata <= req_wdata;
         cur_write <= req_write;
      end
   end

   // R11 pins stay with the controller once the enable has been seen
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         arb_on <= 1'b0;
      else if (arbitration_enable_bit)
         arb_on <= 1'b1;
   end

   // response: error in one cycle, otherwise at the end of the strobe
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
         rsp_rdata <= 16'h0000;
      end else begin
         rsp_valid <= (take && no_bus) || (state == ST_STRB && strb_done);
         rsp_error <= take && no_bus;
         if (state == ST_STRB && strb_done && !cur_write)
            rsp_rdata <= cur_cfg.wide ? data_port_in : {8'h00, data_port_in[7:0]};
      end
   end

   // output decode of the coming state, registered below
   wire in_cycle = (next_state != ST_IDLE) && (next_state != ST_HOLD);
   wire addr_ph  = (next_state == ST_ALE) || (next_state == ST_ALE2);
   wire data_ph  = (next_state == ST_DLY) || (next_state == ST_STRB);
   wire strobe   = (next_state == ST_STRB);
   wire bus_cfg_s nx_cfg = (state == ST_IDLE) ? pick_cfg : cur_cfg;
   wire [23:0] nx_addr   = (state == ST_IDLE) ? req_addr : cur_addr;
   wire [15:0] nx_wdata  = (state == ST_IDLE) ? req_wdata : cur_wdata;
   wire        nx_write  = (state == ST_IDLE) ? req_write : cur_write;
   wire [2:0]  nx_sel    = (state == ST_IDLE) ? pick_sel : cur_sel;
   wire [15:0] lane_mask = nx_cfg.wide ? 16'hffff : 16'h00ff;

   // R14 upper address lines by space size
   wire [7:0] upper_mask = (addr_space_sel == `SPACE_16M) ? `UPPER_MASK_16M :
                           (addr_space_sel == `SPACE_1M)  ? `UPPER_MASK_1M  :
                           (addr_space_sel == `SPACE_256K)? `UPPER_MASK_256K :
                                                            `UPPER_MASK_64K;

   // R3 muxed port carries address then data; R2 demuxed uses two ports
   wire [15:0] nx_data_out = (nx_cfg.mux && addr_ph) ? nx_addr[15:0] : nx_wdata;
   wire        drive_data  = (nx_cfg.mux && addr_ph) || (nx_write && data_ph);
   wire [15:0] nx_data_oe  = !drive_data ? 16'h0000 :
                             (nx_cfg.mux && addr_ph) ? 16'hffff : lane_mask;
   wire [4:0]  nx_cs       = in_cycle ? ~(5'h01 << nx_sel) : `SELECTS_IDLE;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         address_port  <= 16'h0000;
         upper_addr    <= 8'h00;
         data_port_out <= 16'h0000;
         data_port_oe  <= 16'h0000;
         ale           <= 1'b0;
         rd_n          <= 1'b1;
         wr_n          <= 1'b1;
         cs_early      <= `SELECTS_IDLE;
      end else begin
         // R2 demuxed address port
         address_port  <= (in_cycle && !nx_cfg.mux) ? nx_addr[15:0] : 16'h0000;
         upper_addr    <= in_cycle ? (nx_addr[23:16] & upper_mask) : 8'h00;
         data_port_out <= nx_data_out;
         data_port_oe  <= nx_data_oe;
         ale           <= addr_ph;
         rd_n          <= !(strobe && !nx_write);
         wr_n          <= !(strobe && nx_write);
         // R16 selects move with the latch strobe
         cs_early      <= nx_cs;
      end
   end

   // R15 half-cycle late copy on the falling edge
   always_ff @(negedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         cs_half <= `SELECTS_IDLE;
      else
         cs_half <= cs_early;
   end

   // R8 five selects
   assign window_select_out_n = select_timing_bit ? cs_early : cs_half;

   // R17 float first, acknowledge one cycle later
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_oe              <= 1'b1;
         bus_grant_ack_out_n <= 1'b1;
      end else begin
         bus_oe              <= (next_state != ST_HOLD) && (own_bus || next_state != ST_IDLE);
         bus_grant_ack_out_n <= !(state == ST_HOLD && next_state == ST_HOLD);
      end
   end

   // R12 R13 acknowledge pin direction
   assign bus_grant_ack_oe = arb_on && master;
   assign bus_want_out_n   = !(arb_on && req_valid &&
                               ((master && state == ST_HOLD) || (!master && !own_bus)));

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   ale_width_a: assert property ($rose(ale) && !cur_cfg.ale_long |=> !ale) // R4
      else $error("latch strobe too long");
   ale_long_a: assert property ($rose(ale) && cur_cfg.ale_long |=> ale ##1 !ale) // R4
      else $error("long latch strobe wrong");
   ready_wait_a: assert property (state == ST_STRB && cnt == 4'h0 && !ready_ok
                                  |=> state == ST_STRB) // R9
      else $error("cycle ended without ready");
   ready_pol_a: assert property (state == ST_STRB && cnt == 4'h0 && cur_cfg.ready_en
                  && ready_in == cur_cfg.ready_polarity_bit |=> state == ST_RECOV) // R10
      else $error("ready level ignored");
   win_prio_a: assert property (take && hit[3] |=> cur_sel == 3'h4) // R6
      else $error("window four not chosen");
   win_default_a: assert property (take && hit == 4'h0 |=> cur_sel == 3'h0) // R7
      else $error("default not chosen");
   cs_timing_a: assert property ($rose(ale) && select_timing_bit |-> // R16
                                 window_select_out_n == ~(5'h01 << cur_sel))
      else $error("selects not with strobe");
   upper_addr_a: assert property (addr_space_sel == 2'h3 |=> upper_addr == 8'h00) // R14
      else $error("upper lines driven in 64K space");
   hold_float_a: assert property (!bus_grant_ack_out_n |-> !bus_oe && !$past(bus_oe)) // R17
      else $error("acknowledge before float");
   slave_dir_a: assert property (port6_pin7_direction |-> !bus_grant_ack_oe) // R13
      else $error("acknowledge driven in slave mode");
   mux_addr_a: assert property (ale && cur_cfg.mux |-> data_port_out == cur_addr[15:0]) // R3
      else $error("muxed address missing");
   demux_addr_a: assert property (ale && !cur_cfg.mux |-> address_port == cur_addr[15:0]) // R2
      else $error("demuxed address missing");
   byte_lane_a: assert property (!wr_n && !cur_cfg.wide |-> data_port_oe == 16'h00ff) // R2
      else $error("byte write drives upper lane");
   strobe_excl_a: assert property (!(!rd_n && !wr_n)) // R4
      else $error("read and write strobes together");
   cs_one_hot_a: assert property ((!rd_n || !wr_n) |-> // R8
                                  $countones(~window_select_out_n) == 1)
      else $error("not exactly one select during strobe");
   no_bus_err_a: assert property (take && single_chip |=> rsp_valid && rsp_error) // R1
      else $error("single chip access not refused");
   win_pair_a: assert property (take && hit[1] && !hit[2] && !hit[3] |=> // R6
                                cur_sel == 3'h2)
      else $error("window two not chosen over one");
   ale_start_a: assert property (take && !no_bus |=> ale && rd_n && wr_n) // R4
      else $error("cycle not opened by latch strobe");
   hold_entry_a: assert property (state == ST_IDLE && hold_rq |=> !bus_oe) // R17
      else $error("bus not floated on hold");
   slave_float_a: assert property (arb_on && !master && bus_grant_ack_in_n && // R13
                                   state == ST_IDLE |=> !bus_oe)
      else $error("slave drives bus without grant");

   read_c:  cover property (!rd_n ##[1:20] rsp_valid);
   write_c: cover property (!wr_n ##[1:20] rsp_valid);
   hold_c:  cover property (!bus_grant_ack_out_n ##[1:20] bus_oe);
   wait_c:  cover property (state == ST_STRB && cnt == 4'h0 && !ready_ok);
   error_c: cover property (rsp_valid && rsp_error);

endmodule : off_chip_bus_unit

// ===== tb/ext_mem_model.sv
// external memory model on the far side of the off-chip bus
`timescale 1ns/1ps
module ext_mem_model (
   input  wire logic        sys_clk,
   input  wire logic        ale,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   input  wire logic [15:0] address_port,
   input  wire logic [15:0] data_port_out,
   input  wire logic [15:0] data_port_oe,
   input  wire logic        ready_pol,
   input  wire logic [31:0] ready_delay,
   output logic [15:0]      data_port_in,
   output logic             ready_in,
   output logic [15:0]      last_wdata
);
   logic [15:0] addr;
   logic [15:0] junk;
   int          cnt;
   initial begin
      addr = 16'h0000;
      junk = 16'h0000;
      cnt = 0;
      last_wdata = 16'h0000;
   end
   // address taken from the data port when the unit drives it (multiplexed)
   always @(posedge sys_clk) begin
      if (ale === 1'b1)
         addr <= data_port_oe[0] ? data_port_out : address_port;
      cnt <= (rd_n && wr_n) ? 0 : cnt + 1;
      junk <= ~junk;
      if (wr_n === 1'b0)
         last_wdata <= data_port_out;
   end
   // released bus shows a toggling pattern, not the last value
   assign data_port_in = (rd_n === 1'b0) ? (addr ^ 16'h5a5a) : junk;
   assign ready_in = (!(rd_n && wr_n) && cnt >= ready_delay) ? ready_pol : ~ready_pol;
endmodule : ext_mem_model

// ===== tb/external_bus_controller_tb_top.sv
// self-checking testbench of the off-chip bus unit
`timescale 1ns/1ps
module external_bus_controller_tb_top
   import off_chip_bus_pkg::*;
();
   logic sys_clk, reset_n, req_valid, req_ready, req_write, rsp_valid, rsp_error;
   logic single_chip, select_timing_bit, arbitration_enable_bit, port6_pin7_direction;
   logic bus_oe, ale, rd_n, wr_n, ready_in, hold_n, bus_want_out_n;
   logic bus_grant_ack_out_n, bus_grant_ack_oe, bus_grant_ack_in_n, rdy_pol, ale1, err1;
   logic [23:0] req_addr, a;
   logic [15:0] req_wdata, rsp_rdata, address_port, data_port_out, data_port_oe;
   logic [15:0] data_port_in, last_wdata, ap1, dout1, doe1, rdat;
   logic [7:0]  upper_addr, up1;
   logic [4:0]  window_select_out_n, sel1, sel2;
   logic [1:0]  addr_space_sel;
   logic [31:0] seed, r;
   win_sel_s [3:0] wsel;
   bus_cfg_s [3:0] wcfg;
   bus_cfg_s       dcfg;
   int miscompares, compares, lat, rdy_dly, i;
   logic [23:0] wa [5];
   logic [4:0]  ws [5];

   off_chip_bus_unit dut (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid),
      .req_ready(req_ready), .req_write(req_write), .req_addr(req_addr),
      .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_error(rsp_error),
      .rsp_rdata(rsp_rdata), .single_chip(single_chip), .addr_space_sel(addr_space_sel),
      .window_select_reg(wsel), .window_bus_config_reg(wcfg),
      .default_bus_config_reg(dcfg), .select_timing_bit(select_timing_bit),
      .arbitration_enable_bit(arbitration_enable_bit),
      .port6_pin7_direction(port6_pin7_direction), .address_port(address_port),
      .upper_addr(upper_addr), .bus_oe(bus_oe), .data_port_out(data_port_out),
      .data_port_oe(data_port_oe), .data_port_in(data_port_in), .ale(ale), .rd_n(rd_n),
      .wr_n(wr_n), .window_select_out_n(window_select_out_n), .ready_in(ready_in),
      .hold_n(hold_n), .bus_want_out_n(bus_want_out_n),
      .bus_grant_ack_out_n(bus_grant_ack_out_n), .bus_grant_ack_oe(bus_grant_ack_oe),
      .bus_grant_ack_in_n(bus_grant_ack_in_n));

   ext_mem_model mem (.sys_clk(sys_clk), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .address_port(address_port), .data_port_out(data_port_out),
      .data_port_oe(data_port_oe), .ready_pol(rdy_pol), .ready_delay(rdy_dly),
      .data_port_in(data_port_in), .ready_in(ready_in), .last_wdata(last_wdata));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   function automatic logic [7:0] up_mask(input logic [1:0] s);
      return (s == 2'h0) ? 8'hff : (s == 2'h1) ? 8'h0f : (s == 2'h2) ? 8'h03 : 8'h00;
   endfunction : up_mask

   task automatic chk(input logic c, input string m);
      compares++;
      if (c !== 1'b1) begin
         miscompares++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick

   // one request; samples the bus in the first two cycles after the take
   task automatic access(input logic wr, input logic [23:0] ad, input logic [15:0] d);
      int k;
      k = 0;
      tick(1);
      req_valid = 1'b1;
      req_write = wr;
      req_addr = ad;
      req_wdata = d;
      while (req_ready !== 1'b1 && k < 40) begin
         tick(1);
         k++;
      end
      tick(1);
      req_valid = 1'b0;
      {sel1, ap1, up1, dout1, doe1, ale1} = {window_select_out_n, address_port,
         upper_addr, data_port_out, data_port_oe, ale};
      for (lat = 1; lat < 40 && rsp_valid !== 1'b1; lat++) begin
         if (lat == 2)
            sel2 = window_select_out_n;
         @(posedge sys_clk);
         #2;
      end
      rdat = rsp_rdata;
      err1 = rsp_error;
   endtask : access

   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #250000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      {miscompares, compares, rdy_dly, seed} = {32'd0, 32'd0, 32'd3, 32'd34499};
      {reset_n, req_valid, req_write, single_chip, select_timing_bit, rdy_pol} = 6'h00;
      {arbitration_enable_bit, port6_pin7_direction, hold_n, bus_grant_ack_in_n} = 4'h3;
      {req_addr, req_wdata, addr_space_sel} = '0;
      wsel = {win_sel_s'({12'h210, 4'h4}), win_sel_s'({12'h200, 4'h8}),
              win_sel_s'({12'h010, 4'h4}), win_sel_s'({12'h010, 4'h8})};
      dcfg = bus_cfg_s'(12'ha00);
      wcfg = {4{dcfg}};
      tick(3);
      reset_n = 1'b1;
      chk(window_select_out_n === 5'h1f && rd_n === 1'b1 && wr_n === 1'b1, "reset");
      for (i = 0; i < 10; i++) begin
         r = xs();
         dcfg = bus_cfg_s'({1'b1, r[0], r[1], r[2], r[3], r[4], 4'h0, r[6:5]});
         addr_space_sel = r[8:7];
         select_timing_bit = r[9];
         a = {4'h8, r[29:10]};
         access(r[30], a, r[31:16]);
         chk(lat == 3 + r[2] + r[3] + r[6:5], "cycle length");
         chk(up1 === (a[23:16] & up_mask(r[8:7])), "upper address");
         chk(r[0] ? (dout1 === a[15:0] && doe1 === 16'hffff) : ap1 === a[15:0], "addr");
         chk(sel1 === (r[9] ? 5'h1e : 5'h1f), "select timing");
         chk(sel2 === 5'h1e, "default select");
         if (r[30])
            chk(r[1] ? last_wdata === r[31:16] : last_wdata[7:0] === r[23:16], "wr");
         else
            chk(rdat === (r[1] ? a[15:0] ^ 16'h5a5a : {8'h00, a[7:0] ^ 8'h5a}), "rd");
      end
      $display("random cycles done");
      dcfg = bus_cfg_s'(12'ha00);
      {wa[0], wa[1], wa[2], wa[3], wa[4]} = {24'h011234, 24'h030000, 24'h210000,
         24'h230000, 24'h900000};
      {ws[0], ws[1], ws[2], ws[3], ws[4]} = {5'h1b, 5'h1d, 5'h0f, 5'h17, 5'h1e};
      for (i = 0; i < 5; i++) begin
         access(1'b0, wa[i], 16'h0000);
         chk(sel2 === ws[i] && rdat === (wa[i][15:0] ^ 16'h5a5a), "window");
      end
      $display("windows done");
      for (i = 0; i < 2; i++) begin
         rdy_pol = i[0];
         wcfg[0] = bus_cfg_s'({7'h51, i[0], 4'h0});
         access(1'b0, 24'h030000, 16'h0000);
         chk(lat == 3 + rdy_dly && rdat === 16'h5a5a, "ready wait");
      end
      $display("ready done");
      single_chip = 1'b1;
      access(1'b0, 24'h900000, 16'h0000);
      chk(err1 === 1'b1 && lat == 1, "single chip");
      single_chip = 1'b0;
      dcfg = bus_cfg_s'(12'h200);
      access(1'b1, 24'h900000, 16'h1234);
      chk(err1 === 1'b1 && lat == 1, "disabled config");
      $display("errors done");
      arbitration_enable_bit = 1'b1;
      hold_n = 1'b0;
      tick(3);
      chk(bus_oe === 1'b0 && bus_grant_ack_out_n === 1'b0 && req_ready === 1'b0, "hold");
      chk(bus_grant_ack_oe === 1'b1, "master ack output");
      hold_n = 1'b1;
      tick(2);
      chk(bus_oe === 1'b1 && bus_grant_ack_out_n === 1'b1, "hold release");
      port6_pin7_direction = 1'b1;
      dcfg = bus_cfg_s'(12'ha00);
      req_valid = 1'b1;
      tick(2);
      chk(bus_grant_ack_oe === 1'b0, "slave ack input");
      chk(bus_want_out_n === 1'b0 && req_ready === 1'b0 && bus_oe === 1'b0, "slave wait");
      req_valid = 1'b0;
      bus_grant_ack_in_n = 1'b0;
      tick(1);
      chk(bus_want_out_n === 1'b1 && req_ready === 1'b1 && bus_oe === 1'b1, "slave owns");
      $display("arbitration done");
      tally_and_finish();
   end
endmodule : external_bus_controller_tb_top
